// ==== shared/sps_pkg.sv ====
package sps_pkg;
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STRAP_CNT_W = 8;

  // Slave address: fixed upper nibble, three low bits from straps
  localparam logic [3:0] SPS_ADDR_HI = 4'hB;
  localparam int SPS_ADDR_LO_W = 3;

  // Three-level strap codes
  localparam logic [1:0] SPS_LVL_LOW = 2'h0;
  localparam logic [1:0] SPS_LVL_OPEN = 2'h1;
  localparam logic [1:0] SPS_LVL_HIGH = 2'h2;

  // Byte framing
  localparam logic [3:0] SPS_BIT_LAST = 4'h7;
  localparam logic [3:0] SPS_BIT_ACK = 4'h8;
  localparam logic [1:0] SPS_IDX_ADDR_HI = 2'h0;
  localparam logic [1:0] SPS_IDX_ADDR_LO = 2'h1;
  localparam logic [1:0] SPS_IDX_DATA = 2'h2;

  // Synchronised input bit positions
  localparam int SPS_IN_SCL = 0;
  localparam int SPS_IN_SDA = 1;
  localparam int SPS_IN_STRAP_HI = 2;
  localparam int SPS_IN_STRAP_LO = 3;
  localparam int SPS_IN_SLEEP = 4;
  localparam int SPS_IN_N = 5;

  // Write FIFO
  localparam int SPS_FIFO_DEPTH = 8;
  localparam int SPS_REG_AW = 16;
  localparam int SPS_REG_DW = 8;

  typedef enum logic [2:0] {
    SPS_ST_IDLE,
    SPS_ST_DEV,
    SPS_ST_RX,
    SPS_ST_TX,
    SPS_ST_WAIT
  } sps_state_t;

  typedef enum logic [2:0] {
    SPS_PR_DOWN,
    SPS_PR_SAMPLE_DOWN,
    SPS_PR_UP,
    SPS_PR_SAMPLE_UP,
    SPS_PR_DONE
  } sps_probe_t;
endpackage

// ==== core/sps_i2c_slave.sv ====
`timescale 1ns/1ps

module sps_fifo
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // sps_fifo

module sps_i2c_slave
  import sps_pkg::*;
#(
  parameter int FIFO_DEPTH = SPS_FIFO_DEPTH,
  parameter int STRAP_SETTLE = STRAP_SETTLE_CYC
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic port_select_high_strap,
  input wire logic port_select_low_strap,
  output logic strap_pull_up,
  input wire logic chip_sleep_pin_n,
  output logic chip_asleep,
  output logic spi_select,
  output logic i2c_select,
  output logic [SPS_ADDR_LO_W-1:0] slave_addr_lo,
  output logic cfg_wr_valid,
  input wire logic cfg_wr_ready,
  output logic [SPS_REG_AW-1:0] cfg_wr_addr,
  output logic [SPS_REG_DW-1:0] cfg_wr_data,
  output logic [SPS_REG_AW-1:0] cfg_rd_addr,
  input wire logic [SPS_REG_DW-1:0] cfg_rd_data
);
  logic [SPS_IN_N-1:0] pins;
  logic [SPS_IN_N-1:0] s1_reg;
  logic [SPS_IN_N-1:0] s2_reg;
  logic [SPS_IN_N-1:0] s3_reg;
  logic [SPS_IN_N-1:0] filt_reg;
  logic [SPS_IN_N-1:0] filt_d_reg;

  sps_probe_t probe_reg;
  logic [STRAP_CNT_W-1:0] settle_reg;
  logic [1:0] down_read_reg;
  logic [1:0] lvl_hi_reg;
  logic [1:0] lvl_lo_reg;
  logic pull_up_reg;
  logic spi_reg;
  logic i2c_reg;
  logic [SPS_ADDR_LO_W-1:0] addr_lo_reg;
  logic sleep_reg;

  sps_state_t state_reg;
  logic [3:0] bit_reg;
  logic [1:0] idx_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic rw_reg;
  logic acked_reg;
  logic mnack_reg;
  logic sda_oe_n_reg;
  logic [SPS_REG_AW-1:0] raddr_reg;
  logic skip_reg;

  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic push_valid;
  logic push_ready;
  logic addr_match;

  assign pins = {chip_sleep_pin_n, port_select_low_strap, port_select_high_strap, sda_i, scl_i};

  // Three-stage synchroniser; a change is taken when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SPS_IN_N; gi++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          s1_reg[gi] <= 1'b1;
          s2_reg[gi] <= 1'b1;
          s3_reg[gi] <= 1'b1;
          filt_reg[gi] <= 1'b1;
          filt_d_reg[gi] <= 1'b1;
        end
        else
        begin
          s1_reg[gi] <= pins[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi])
          begin
            filt_reg[gi] <= s3_reg[gi];
          end
          filt_d_reg[gi] <= filt_reg[gi];
        end
      end
    end
  endgenerate

  assign scl_f = filt_reg[SPS_IN_SCL];
  assign sda_f = filt_reg[SPS_IN_SDA];
  // Edge sampling at 200 MHz leaves ample margin at 100 and 400 kHz
  assign scl_rise = scl_f && !filt_d_reg[SPS_IN_SCL];
  assign scl_fall = !scl_f && filt_d_reg[SPS_IN_SCL];
  assign start_cond = scl_f && filt_d_reg[SPS_IN_SCL] && !sda_f && filt_d_reg[SPS_IN_SDA];
  assign stop_cond = scl_f && filt_d_reg[SPS_IN_SCL] && sda_f && !filt_d_reg[SPS_IN_SDA];
  assign addr_match = i2c_reg && (rx_reg[7:1] == {SPS_ADDR_HI, addr_lo_reg});

  // Strap probe: read each pin with a weak pull down, then with a weak pull up
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      probe_reg <= SPS_PR_DOWN;
      settle_reg <= '0;
      pull_up_reg <= 1'b0;
      down_read_reg <= 2'h0;
      lvl_hi_reg <= SPS_LVL_LOW;
      lvl_lo_reg <= SPS_LVL_LOW;
    end
    else
    begin
      case (probe_reg)
        SPS_PR_DOWN, SPS_PR_UP:
        begin
          settle_reg <= settle_reg + 1'b1;
          if (settle_reg == STRAP_CNT_W'(STRAP_SETTLE - 1))
          begin
            settle_reg <= '0;
            probe_reg <= (probe_reg == SPS_PR_DOWN) ? SPS_PR_SAMPLE_DOWN : SPS_PR_SAMPLE_UP;
          end
        end
        SPS_PR_SAMPLE_DOWN:
        begin
          down_read_reg <= {filt_reg[SPS_IN_STRAP_HI], filt_reg[SPS_IN_STRAP_LO]};
          pull_up_reg <= 1'b1;
          probe_reg <= SPS_PR_UP;
        end
        SPS_PR_SAMPLE_UP:
        begin
          // Pin follows the pull only when open
          lvl_hi_reg <= down_read_reg[1] ? SPS_LVL_HIGH :
            (filt_reg[SPS_IN_STRAP_HI] ? SPS_LVL_OPEN : SPS_LVL_LOW);
          lvl_lo_reg <= down_read_reg[0] ? SPS_LVL_HIGH :
            (filt_reg[SPS_IN_STRAP_LO] ? SPS_LVL_OPEN : SPS_LVL_LOW);
          pull_up_reg <= 1'b0;
          probe_reg <= SPS_PR_DONE;
        end
        SPS_PR_DONE:
        begin
          probe_reg <= SPS_PR_DONE;
        end
        default:
        begin
          probe_reg <= SPS_PR_DOWN;
        end
      endcase
    end
  end

  // Port selection and address low bits
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      spi_reg <= 1'b0;
      i2c_reg <= 1'b0;
      addr_lo_reg <= '0;
    end
    else if (probe_reg == SPS_PR_DONE)
    begin
      spi_reg <= (lvl_hi_reg == SPS_LVL_HIGH) && (lvl_lo_reg == SPS_LVL_HIGH);
      i2c_reg <= !((lvl_hi_reg == SPS_LVL_HIGH) && (lvl_lo_reg == SPS_LVL_HIGH));
      addr_lo_reg <= {1'b0, lvl_hi_reg} * 3'h3 + {1'b0, lvl_lo_reg};
    end
  end

  // Sleep status is reported only; the port is never gated by it
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sleep_reg <= 1'b0;
    end
    else
    begin
      sleep_reg <= !filt_reg[SPS_IN_SLEEP];
    end
  end

  // Write data is queued toward the register file; a full queue nacks the byte
  assign push_valid = scl_fall && (state_reg == SPS_ST_RX) && (bit_reg == SPS_BIT_LAST)
    && (idx_reg == SPS_IDX_DATA);

  sps_fifo
  #(
    .WIDTH(SPS_REG_AW + SPS_REG_DW),
    .DEPTH(FIFO_DEPTH)
  )
  u_fifo
  (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data({raddr_reg, rx_reg}),
    .out_valid(cfg_wr_valid),
    .out_ready(cfg_wr_ready),
    .out_data({cfg_wr_addr, cfg_wr_data})
  );

  // Byte receive shift register, MSB first
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rx_reg <= 8'h00;
      mnack_reg <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (bit_reg < SPS_BIT_ACK)
      begin
        rx_reg <= {rx_reg[6:0], sda_f};
      end
      else if (state_reg == SPS_ST_TX)
      begin
        mnack_reg <= sda_f;
      end
    end
  end

  // Transfer sequencer; data line only changes after a falling clock
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg <= SPS_ST_IDLE;
      bit_reg <= 4'h0;
      idx_reg <= SPS_IDX_ADDR_HI;
      rw_reg <= 1'b0;
      acked_reg <= 1'b0;
      tx_reg <= 8'h00;
      sda_oe_n_reg <= 1'b1;
      raddr_reg <= '0;
      skip_reg <= 1'b0;
    end
    else if (start_cond)
    begin
      state_reg <= SPS_ST_DEV;
      bit_reg <= 4'h0;
      sda_oe_n_reg <= 1'b1;
      // The clock fall that closes the start carries no data bit
      skip_reg <= 1'b1;
    end
    else if (stop_cond)
    begin
      state_reg <= SPS_ST_IDLE;
      bit_reg <= 4'h0;
      sda_oe_n_reg <= 1'b1;
      skip_reg <= 1'b0;
    end
    else if (scl_fall && skip_reg)
    begin
      skip_reg <= 1'b0;
    end
    else if (scl_fall && (state_reg != SPS_ST_IDLE) && (state_reg != SPS_ST_WAIT))
    begin
      if (bit_reg < SPS_BIT_LAST)
      begin
        bit_reg <= bit_reg + 1'b1;
        if (state_reg == SPS_ST_TX)
        begin
          sda_oe_n_reg <= tx_reg[6 - bit_reg[2:0]];
        end
      end
      else if (bit_reg == SPS_BIT_LAST)
      begin
        bit_reg <= SPS_BIT_ACK;
        case (state_reg)
          SPS_ST_DEV:
          begin
            acked_reg <= addr_match;
            rw_reg <= rx_reg[0];
            sda_oe_n_reg <= !addr_match;
          end
          SPS_ST_RX:
          begin
            acked_reg <= (idx_reg != SPS_IDX_DATA) || push_ready;
            sda_oe_n_reg <= !((idx_reg != SPS_IDX_DATA) || push_ready);
          end
          default:
          begin
            sda_oe_n_reg <= 1'b1;
          end
        endcase
      end
      else
      begin
        bit_reg <= 4'h0;
        sda_oe_n_reg <= 1'b1;
        case (state_reg)
          SPS_ST_DEV:
          begin
            if (!acked_reg)
            begin
              state_reg <= SPS_ST_WAIT;
            end
            else if (rw_reg)
            begin
              state_reg <= SPS_ST_TX;
              tx_reg <= cfg_rd_data;
              sda_oe_n_reg <= cfg_rd_data[7];
              raddr_reg <= raddr_reg + 1'b1;
            end
            else
            begin
              state_reg <= SPS_ST_RX;
              idx_reg <= SPS_IDX_ADDR_HI;
            end
          end
          SPS_ST_RX:
          begin
            if (!acked_reg)
            begin
              state_reg <= SPS_ST_WAIT;
            end
            else
            begin
              case (idx_reg)
                SPS_IDX_ADDR_HI:
                begin
                  raddr_reg[15:8] <= rx_reg;
                  idx_reg <= SPS_IDX_ADDR_LO;
                end
                SPS_IDX_ADDR_LO:
                begin
                  raddr_reg[7:0] <= rx_reg;
                  idx_reg <= SPS_IDX_DATA;
                end
                default:
                begin
                  raddr_reg <= raddr_reg + 1'b1;
                end
              endcase
            end
          end
          SPS_ST_TX:
          begin
            if (mnack_reg)
            begin
              state_reg <= SPS_ST_WAIT;
            end
            else
            begin
              tx_reg <= cfg_rd_data;
              sda_oe_n_reg <= cfg_rd_data[7];
              raddr_reg <= raddr_reg + 1'b1;
            end
          end
          default:
          begin
            state_reg <= SPS_ST_WAIT;
          end
        endcase
      end
    end
  end

  // Open-drain data: only ever pulled low; the clock line has no driver here
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sda_o <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
    end
  end

  assign sda_oe_n = sda_oe_n_reg;
  assign strap_pull_up = pull_up_reg;
  assign chip_asleep = sleep_reg;
  assign spi_select = spi_reg;
  assign i2c_select = i2c_reg;
  assign slave_addr_lo = addr_lo_reg;
  assign cfg_rd_addr = raddr_reg;
endmodule // sps_i2c_slave

// ==== tb/sps_chk.sv ====
`timescale 1ns/1ps
module sps_chk
  import sps_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic port_select_high_strap,
  input wire logic port_select_low_strap,
  input wire logic chip_sleep_pin_n,
  input wire logic chip_asleep,
  input wire logic spi_select,
  input wire logic i2c_select,
  input wire logic cfg_wr_valid,
  input wire logic cfg_wr_ready,
  input wire logic [SPS_REG_AW-1:0] cfg_wr_addr,
  input wire logic [SPS_REG_DW-1:0] cfg_wr_data
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  drive_low_a: assert property (sda_o == 1'b0)
    else $error("data output not low");
  sel_excl_a: assert property (!(spi_select && i2c_select))
    else $error("both ports selected");
  spi_strap_a: assert property (spi_select |-> port_select_high_strap && port_select_low_strap)
    else $error("spi chosen without both straps high");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> sda_oe_n && !i2c_select)
    else $error("outputs active after reset");
  sda_change_a: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("data drive changed with clock high");
  ack_hold_a: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*8])
    else $error("data drive too short");
  wr_hold_a: assert property (cfg_wr_valid && !cfg_wr_ready |=> cfg_wr_valid && $stable(cfg_wr_addr) && $stable(cfg_wr_data))
    else $error("write head changed while stalled");
  sleep_track_a: assert property ($stable(chip_sleep_pin_n) [*6] |-> chip_asleep == !chip_sleep_pin_n)
    else $error("sleep flag wrong");
  push_low_a: assert property ($rose(cfg_wr_valid) |-> !scl_i)
    else $error("write pushed with clock high");
endmodule // sps_chk

bind sps_i2c_slave sps_chk u_chk (
  .clock, .rst_n, .scl_i, .sda_o, .sda_oe_n, .port_select_high_strap, .port_select_low_strap,
  .chip_sleep_pin_n, .chip_asleep, .spi_select, .i2c_select, .cfg_wr_valid, .cfg_wr_ready,
  .cfg_wr_addr, .cfg_wr_data
);

// ==== tb/sps_mst.sv ====
`timescale 1ns/1ps
module sps_mst
(
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic start_c();
    sda_m = 1'b1;
    #40 scl = 1'b1;
    #40 sda_m = 1'b0;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic stop_c();
    sda_m = 1'b0;
    #40 scl = 1'b1;
    #40 sda_m = 1'b1;
    #40;
  endtask
  // One clock pulse per bit, data moved only while clock low
  task automatic bitx(input logic b, output logic r);
    sda_m = b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, ack);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask
endmodule // sps_mst

// ==== tb/sps_i2c_slave_tb_top.sv ====
`timescale 1ns/1ps
module sps_i2c_slave_tb_top;
  import sps_pkg::*;
  logic clock, rst_n, scl, sda_m, sda, sda_o, sda_oe_n, pull_up, sleep_n, asleep, ack;
  logic spi_sel, i2c_sel, wr_valid, wr_ready;
  logic [2:0] addr_lo;
  logic [15:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data, d;
  logic [1:0] hi_lvl, lo_lvl;
  logic [7:0] mem [0:65535];
  logic [7:0] rows [9] = '{8'h00, 8'h11, 8'h22, 8'h43, 8'h54, 8'h65, 8'h86, 8'h97, 8'hA8};
  int fail_count, total_checks, pushes, p0;
  assign sda = sda_m & (sda_oe_n | sda_o);
  assign rd_data = mem[rd_addr];
  sps_mst u_mst (.scl(scl), .sda_m(sda_m), .sda(sda));
  sps_i2c_slave #(.STRAP_SETTLE(4)) u_dut (
    .clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .port_select_high_strap(hi_lvl[1] | (hi_lvl[0] & pull_up)),
    .port_select_low_strap(lo_lvl[1] | (lo_lvl[0] & pull_up)), .strap_pull_up(pull_up),
    .chip_sleep_pin_n(sleep_n), .chip_asleep(asleep), .spi_select(spi_sel),
    .i2c_select(i2c_sel), .slave_addr_lo(addr_lo), .cfg_wr_valid(wr_valid),
    .cfg_wr_ready(wr_ready), .cfg_wr_addr(wr_addr), .cfg_wr_data(wr_data),
    .cfg_rd_addr(rd_addr), .cfg_rd_data(rd_data)
  );
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    if (wr_valid && wr_ready)
    begin
      mem[wr_addr] <= wr_data;
      pushes <= pushes + 1;
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chkv({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic w(input logic [7:0] b, input logic exp_ack);
    u_mst.wbyte(b, ack);
    chkb(ack, exp_ack);
  endtask
  task automatic do_reset(input logic [3:0] lv);
    @(negedge clock);
    {hi_lvl, lo_lvl} = lv;
    rst_n = 1'b0;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    for (int i = 0; i < 100 && !(i2c_sel || spi_sel); i++)
      @(negedge clock);
  endtask
  initial
  begin
    #400000;
    fail_count++;
    end_of_test();
  end
  initial
  begin
    rst_n = 1'b0;
    sleep_n = 1'b1;
    wr_ready = 1'b1;
    {hi_lvl, lo_lvl} = 4'h0;
    pushes = 0;
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h3C;
    foreach (rows[k])
    begin
      do_reset(rows[k][7:4]);
      chkb(spi_sel, rows[k][3]);
      chkb(i2c_sel, !rows[k][3]);
      chkb(pull_up, 1'b0);
      if (!rows[k][3])
      begin
        chkv({13'h0000, addr_lo}, {13'h0000, rows[k][2:0]});
        u_mst.start_c();
        w({4'hB, rows[k][2:0], 1'b0}, 1'b0);
        u_mst.start_c();
        w({4'hB, rows[k][2:0] ^ 3'h1, 1'b0}, 1'b1);
        u_mst.stop_c();
      end
      $display("strap row %0d done", k);
    end
    do_reset(4'h0);
    sleep_n = 1'b0;
    u_mst.start_c();
    w(8'hB0, 1'b0);
    w(8'h12, 1'b0);
    w(8'hFF, 1'b0);
    w(8'h5A, 1'b0);
    w(8'hA5, 1'b0);
    u_mst.stop_c();
    u_mst.start_c();
    w(8'hB0, 1'b0);
    w(8'h12, 1'b0);
    w(8'hFF, 1'b0);
    u_mst.start_c();
    w(8'hB1, 1'b0);
    u_mst.rbyte(1'b0, d);
    chkv({8'h00, d}, 16'h005A);
    u_mst.rbyte(1'b1, d);
    chkv({8'h00, d}, 16'h00A5);
    chkb(sda, 1'b1);
    u_mst.stop_c();
    chkb(asleep, 1'b1);
    chkv({8'h00, mem[16'h12FF]}, 16'h005A);
    chkv({8'h00, mem[16'h1300]}, 16'h00A5);
    chkv(rd_addr, 16'h1301);
    @(negedge clock);
    sleep_n = 1'b1;
    wr_ready = 1'b0;
    p0 = pushes;
    $display("write read sleep test done");
    u_mst.start_c();
    w(8'hB0, 1'b0);
    w(8'h00, 1'b0);
    w(8'h00, 1'b0);
    for (int i = 0; i < 9; i++)
      w(8'h40 + i[7:0], i == 8);
    u_mst.stop_c();
    chkv(16'(pushes - p0), 16'h0000);
    @(negedge clock);
    wr_ready = 1'b1;
    repeat (20) @(negedge clock);
    chkv(16'(pushes - p0), 16'h0008);
    chkv({8'h00, mem[16'h0007]}, 16'h0047);
    chkb(asleep, 1'b0);
    $display("fifo full test done");
    p0 = pushes;
    u_mst.start_c();
    w(8'hB0, 1'b0);
    w(8'h00, 1'b0);
    w(8'h20, 1'b0);
    for (int i = 0; i < 4; i++)
      u_mst.bitx(1'b1, ack);
    u_mst.stop_c();
    repeat (20) @(negedge clock);
    chkv(16'(pushes - p0), 16'h0000);
    u_mst.start_c();
    w(8'hB0, 1'b0);
    u_mst.stop_c();
    $display("abort test done");
    end_of_test();
  end
endmodule // sps_i2c_slave_tb_top
